// ==== shared/bpp_map.svh ====
// Address map, reset values and fixed codes of the bidirectional printer port.
`ifndef BPP_MAP_SVH
`define BPP_MAP_SVH

`define BPP_PRI_FIRST   10'h378
`define BPP_PRI_LAST    10'h37f
`define BPP_SEC_FIRST   10'h3bc
`define BPP_SEC_LAST    10'h3bf
`define BPP_DATA_OFS    10'h000
`define BPP_DATA_RST    8'hff
`define BPP_ALL_ONES    8'hff
`define BPP_UNMAPPED_RD 8'hff
`define BPP_LINE_LOW    1'b0
`define BPP_DEC_W       10
`define BPP_FLAG_RST    1'b0

`endif

// ==== shared/bpp_pkg.sv ====
// Types shared by the printer port modules.
package bpp_pkg;
    typedef enum logic {
        BPP_RANGE_SEC,
        BPP_RANGE_PRI
    } bpp_range_type;

    typedef logic [7:0] bpp_byte_type;
endpackage : bpp_pkg

// ==== shared/bpp_line_if.sv ====
// Carrier between the port core and its open collector line stage.
interface bpp_line_if #(
    parameter int DATA_W = 8
);
    logic [DATA_W-1:0] level;
    logic [DATA_W-1:0] sample;

    modport ctl (
        output level,
        input  sample
    );

    modport drv (
        input  level,
        output sample
    );
endinterface : bpp_line_if

// ==== rtl/bpp_line_drv.sv ====
// Open collector data line stage with registered input sampling.
`include "bpp_map.svh"

module bpp_line_drv #(
    parameter int DATA_W = 8
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    bpp_line_if.drv                lines,
    input  wire logic [DATA_W-1:0] dataLineIn,
    output logic      [DATA_W-1:0] dataLineOut,
    output logic      [DATA_W-1:0] dataLineOe
);

    logic [DATA_W-1:0] sample_r;

    // R3 pull low only
    assign dataLineOut = {DATA_W{`BPP_LINE_LOW}};
    // R3 release on one
    assign dataLineOe  = ~lines.level;

    // R2 sample line levels
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_r <= '1;
        end else begin
            sample_r <= dataLineIn;
        end
    end

    assign lines.sample = sample_r;

endmodule : bpp_line_drv

// ==== rtl/bpp_port.sv ====
// Bidirectional parallel printer port data register and address decode.
`include "bpp_map.svh"

// Function
// R1: Configuration input picks 378-37Fh when asserted, else 3BC-3BFh; asserted is default.
// R2: All eight data lines are driven from the output register and read back.
// R3: Each driver pulls low only for a zero bit, otherwise releases to pull-up.
// R4: With register all ones, data address read returns the external line levels.
// R5: Software writes 0FFh to the data register before using lines as inputs.
// R6: Data address reads always return line levels, so driven-low bits read zero.
module bpp_port #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 10
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              portAddressSelect,
    input  wire logic [ADDR_W-1:0] ioAddr,
    input  wire logic              ioWrite,
    input  wire logic              ioRead,
    input  wire logic [DATA_W-1:0] ioWrData,
    output logic      [DATA_W-1:0] ioRdData,
    output logic                   ioRdValid,
    output logic                   ioHit,
    output logic                   linesReleased,
    input  wire logic [DATA_W-1:0] dataLineIn,
    output logic      [DATA_W-1:0] dataLineOut,
    output logic      [DATA_W-1:0] dataLineOe
);

    // Only the low ten address bits are decoded, as on the host bus, so a wider bus aliases.
    localparam int DEC_W = `BPP_DEC_W;

    // R1 window bounds
    localparam logic [9:0] PRI_FIRST = `BPP_PRI_FIRST;
    localparam logic [9:0] PRI_LAST  = `BPP_PRI_LAST;
    localparam logic [9:0] SEC_FIRST = `BPP_SEC_FIRST;
    localparam logic [9:0] SEC_LAST  = `BPP_SEC_LAST;
    localparam logic [9:0] DATA_OFS  = `BPP_DATA_OFS;

    // Widths that the fixed decode and the byte-wide register cannot serve are refused here.
    if (DATA_W != 8) begin : g_bad_data_w
        $error("bpp_port serves an eight bit data path only");
    end

    if (ADDR_W < DEC_W) begin : g_bad_addr_w
        $error("bpp_port needs at least ten address bits");
    end

    // R1 window range test
    function automatic logic inWindow(
        input logic [9:0] addr,
        input logic [9:0] first,
        input logic [9:0] last
    );
        inWindow = (addr >= first) && (addr <= last);
    endfunction : inWindow

    // R1 chosen window hit
    function automatic logic windowHit(
        input bpp_pkg::bpp_range_type winSel,
        input logic                   priIn,
        input logic                   secIn
    );
        windowHit = (winSel == bpp_pkg::BPP_RANGE_PRI) ? priIn : secIn;
    endfunction : windowHit

    // R1 base of window
    function automatic logic [9:0] windowBase(
        input bpp_pkg::bpp_range_type winSel
    );
        windowBase = (winSel == bpp_pkg::BPP_RANGE_PRI) ? PRI_FIRST : SEC_FIRST;
    endfunction : windowBase

    // R2 data register address
    function automatic logic isDataAddr(
        input logic [9:0] addr,
        input logic [9:0] base
    );
        isDataAddr = (addr == (base + DATA_OFS));
    endfunction : isDataAddr

    // R4 line levels returned
    // The stored byte is never returned: a bit the port pulls low already reads low on its line.
    function automatic logic [DATA_W-1:0] readSelect(
        input logic              isData,
        input logic [DATA_W-1:0] levels
    );
        readSelect = isData ? levels : `BPP_UNMAPPED_RD;
    endfunction : readSelect

    // R5 all drivers released
    function automatic logic allOnes(
        input logic [DATA_W-1:0] value
    );
        allOnes = (value == `BPP_ALL_ONES);
    endfunction : allOnes

    // The open collector stage sits behind this carrier.
    bpp_line_if #(.DATA_W(DATA_W)) lines ();

    // Address decode.
    bpp_pkg::bpp_range_type rangeSel;
    logic [9:0]             lowAddr;
    logic [9:0]             baseAddr;
    logic                   priHit;
    logic                   secHit;
    logic                   portHit;
    logic                   dataHit;

    // Strobes and next values.
    logic                   rdTaken;
    logic                   wrTaken;
    logic                   accTaken;
    logic                   dataWrite;
    logic [DATA_W-1:0]      rdMux;
    logic [DATA_W-1:0]      outReg_nxt;
    logic [DATA_W-1:0]      rdData_nxt;
    logic                   rdValid_nxt;
    logic                   hit_nxt;

    // Flops.
    logic [DATA_W-1:0]      outReg_r;
    logic [DATA_W-1:0]      rdData_r;
    logic                   rdValid_r;
    logic                   hit_r;

    // R1 pick address range
    assign rangeSel = portAddressSelect ? bpp_pkg::BPP_RANGE_PRI : bpp_pkg::BPP_RANGE_SEC;
    assign lowAddr  = ioAddr[9:0];
    assign priHit   = inWindow(lowAddr, PRI_FIRST, PRI_LAST);
    assign secHit   = inWindow(lowAddr, SEC_FIRST, SEC_LAST);

    // R1 decode chosen window
    assign portHit  = windowHit(rangeSel, priHit, secHit);
    assign baseAddr = windowBase(rangeSel);
    assign dataHit  = portHit && isDataAddr(lowAddr, baseAddr);

    // R1 strobes in window
    // Accesses to the other window are ignored, so a second port can share the bus.
    assign rdTaken  = ioRead && portHit;
    assign wrTaken  = ioWrite && portHit;
    assign accTaken = rdTaken || wrTaken;

    // R2 load output register
    assign dataWrite  = wrTaken && dataHit;
    assign outReg_nxt = dataWrite ? ioWrData : outReg_r;

    // R5 released when all ones
    assign linesReleased = allOnes(outReg_r);

    // R4 return line levels
    // R6 driven bits read low
    // Status and control offsets are not served here and read as all ones.
    // The line sample is one cycle old, which no host polling loop can notice.
    assign rdMux = readSelect(dataHit, lines.sample);

    // R3 enables from register
    assign lines.level = outReg_r;

    // R2 output register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            outReg_r <= `BPP_DATA_RST;
        end else begin
            outReg_r <= outReg_nxt;
        end
    end

    // A read answers one edge after it is taken, so the bus sees flop outputs only.
    // The read data holds between reads, so a slow host may still pick it up late.
    assign rdData_nxt  = rdTaken ? rdMux : rdData_r;
    assign rdValid_nxt = rdTaken;
    assign hit_nxt     = accTaken;

    // R4 hold read data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData_r <= `BPP_UNMAPPED_RD;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    // R1 read answer pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdValid_r <= `BPP_FLAG_RST;
        end else begin
            rdValid_r <= rdValid_nxt;
        end
    end

    // R1 access answer pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hit_r <= `BPP_FLAG_RST;
        end else begin
            hit_r <= hit_nxt;
        end
    end

    // Bus outputs come straight from flops, with no logic between them and the pins.
    assign ioRdData  = rdData_r;
    assign ioRdValid = rdValid_r;
    assign ioHit     = hit_r;

    // R3 open collector stage
    bpp_line_drv #(
        .DATA_W(DATA_W)
    ) u_line (
        .core_clk   (core_clk),
        .rst        (rst),
        .lines      (lines.drv),
        .dataLineIn (dataLineIn),
        .dataLineOut(dataLineOut),
        .dataLineOe (dataLineOe)
    );

endmodule : bpp_port

// ==== bench/bpp_port_assertions.sv ====
// Concurrent checks on the printer port top-level ports.
module bpp_port_assertions (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       portAddressSelect,
    input wire logic [9:0] ioAddr,
    input wire logic       ioWrite,
    input wire logic       ioRead,
    input wire logic [7:0] ioWrData,
    input wire logic [7:0] ioRdData,
    input wire logic       ioRdValid,
    input wire logic       ioHit,
    input wire logic       linesReleased,
    input wire logic [7:0] dataLineIn,
    input wire logic [7:0] dataLineOut,
    input wire logic [7:0] dataLineOe
);
    timeunit 1ns;
    timeprecision 1ns;
    wire inWin  = portAddressSelect ? ioAddr[9:3] == 7'h6f : ioAddr[9:2] == 8'hef;
    wire atBase = inWin && (portAddressSelect ? ioAddr[2:0] == 3'h0 : ioAddr[1:0] == 2'h0);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence sRdAsk; ioRead && atBase; endsequence
    sequence sRdAns; ioRdValid && ioHit; endsequence
    AST_RD: assert property (sRdAsk |=> sRdAns ##0 ioRdData == $past(dataLineIn, 2))
        else $error("data read did not return the line levels");
    AST_OE: assert property (ioWrite && atBase |=> dataLineOe == ~$past(ioWrData))
        else $error("line enables do not follow the written byte");
    AST_KEEP: assert property (!(ioWrite && inWin) |=> $stable(dataLineOe))
        else $error("line enables changed without a write");
    AST_OC: assert property (dataLineOut == 8'h00)
        else $error("line driver output is not low");
    AST_REL: assert property (linesReleased == (dataLineOe == 8'h00))
        else $error("released flag disagrees with the enables");
    AST_HIT: assert property ((ioRead || ioWrite) && inWin |=> ioHit)
        else $error("access in the window was not answered");
    AST_MISS: assert property (!((ioRead || ioWrite) && inWin) |=> !ioHit && !ioRdValid)
        else $error("access outside the window was answered");
    AST_RDV: assert property (ioRdValid |-> $past(ioRead && inWin))
        else $error("read valid without a read in the window");
endmodule : bpp_port_assertions

bind bpp_port bpp_port_assertions u_chk (.core_clk, .rst, .portAddressSelect, .ioAddr, .ioWrite, .ioRead,
    .ioWrData, .ioRdData, .ioRdValid, .ioHit, .linesReleased, .dataLineIn, .dataLineOut, .dataLineOe);

// ==== bench/bpp_printer_model.sv ====
// Printer side of the data lines: pull-ups and an optional open collector drive.
module bpp_printer_model (
    input  wire logic [7:0] oe,
    input  wire logic       drive,
    input  wire logic [7:0] val,
    output logic      [7:0] lines
);
    timeunit 1ns;
    timeprecision 1ns;
    assign lines = ~oe & (drive ? val : 8'hff);
endmodule : bpp_printer_model

// ==== bench/bidir_parallel_printer_port_tb.sv ====
// Self-checking bench of the printer port with a printer on its data lines.
module bidir_parallel_printer_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk = 1'b0, rst = 1'b1, sel = 1'b1, ioWrite = 1'b0, ioRead = 1'b0, drv = 1'b0;
    logic       ioRdValid, ioHit, rel;
    logic [9:0] ioAddr   = 10'h000;
    logic [7:0] ioWrData = 8'h00, ext = 8'h00, v, ioRdData, lineIn, lineOut, lineOe;
    int         n_fail   = 0, cmp_count = 0;
    bpp_port dut (.core_clk, .rst, .portAddressSelect(sel), .ioAddr, .ioWrite, .ioRead, .ioWrData, .ioRdData,
        .ioRdValid, .ioHit, .linesReleased(rel), .dataLineIn(lineIn), .dataLineOut(lineOut), .dataLineOe(lineOe));
    bpp_printer_model prn (.oe(lineOe), .drive(drv), .val(ext), .lines(lineIn));
    initial forever #50 core_clk = ~core_clk;
    function automatic logic [9:0] base(input logic s);
        return s ? 10'h378 : 10'h3bc;
    endfunction : base
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    // Idle two cycles so the line sample has settled, then one strobe.
    task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d);
        repeat (2) @(negedge core_clk);
        ioWrite = w;
        ioRead = ~w;
        ioAddr = a;
        ioWrData = d;
        @(negedge core_clk);
        ioWrite = 1'b0;
        ioRead = 1'b0;
    endtask : io
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        v = 8'($urandom(93));
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        check("enables", lineOe, 8'h00);
        for (int i = 0; i < 24; i++) begin
            sel = i[0];
            // every fourth byte releases all lines.
            v = (i % 4 == 1) ? 8'hff : 8'($urandom);
            ext = 8'($urandom);
            drv = 1'($urandom);
            io(1'b1, base(sel), v);
            check("write hit", {7'h00, ioHit}, 8'h01);
            io(1'b0, base(sel), 8'h00);
            check("read", ioRdData, v & (drv ? ext : 8'hff));
            check("valid", {7'h00, ioRdValid}, 8'h01);
            check("read hit", {7'h00, ioHit}, 8'h01);
            io(1'b1, base(~sel), ~v);
            check("enables", lineOe, ~v);
            check("foreign hit", {7'h00, ioHit}, 8'h00);
            check("drive", lineOut, 8'h00);
            check("released", {7'h00, rel}, {7'h00, v == 8'hff});
            io(1'b0, base(sel) + 10'h001, 8'h00);
            check("other offset", ioRdData, 8'hff);
            check("other valid", {7'h00, ioRdValid}, 8'h01);
            io(1'b0, base(~sel), 8'h00);
            check("foreign valid", {7'h00, ioRdValid}, 8'h00);
            check("held data", ioRdData, 8'hff);
        end
        // A reset in mid-run must release every line and drop the read answer.
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        check("reset enables", lineOe, 8'h00);
        check("reset valid", {7'h00, ioRdValid}, 8'h00);
        io(1'b0, base(sel), 8'h00);
        check("read after reset", ioRdData, drv ? ext : 8'hff);
        tally_and_finish();
    end
endmodule : bidir_parallel_printer_port_tb
